// file: rx_link_consts.vh
`ifndef RX_LINK_CONSTS_VH
`define RX_LINK_CONSTS_VH
`define ADR_CTRL 6'h00
`define ADR_CFG0 6'h01
`define ADR_CFG1 6'h02
`define ADR_STATUS 6'h03
`define ADR_ADJUST 6'h04
`define CTRL_ENABLE 0
`define CTRL_SUB_POS 1
`define CTRL_RESYNC 3
`define CFG0_K_POS 16
`define CFG0_L_POS 24
`define CFG1_CS_POS 4
`define ST_ERR 3
`define ST_ALIGN_POS 8
`define ST_CGS_POS 16
`define RST_F 9'h002
`define RST_K 6'h09
`define RST_L 3'h0
`define RST_CF 3'h0
`define RST_CS 2'h0
`define RST_SUB 2'h0
`define K28_0 8'h1c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_5 8'hbc
`define COMMA_MIN 3'h4
`define CFG_OCTETS 4'he
`define ILA_TIMEOUT_MULT 2
`endif

// file: rx_link_sync.v
`timescale 1ns/1ps
`include "rx_link_consts.vh"
module rx_link_sync #(
    parameter MAX_LANES = 8,
    parameter OPC = 8
) (
    input wire sys_clk, // 50 MHz system and lane clock
    input wire arst_n, // asynchronous reset, active low
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [7:0] wb_adr_i, // Wishbone byte address
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    input wire [MAX_LANES*OPC*8-1:0] rx_data, // decoded lane octets
    input wire [MAX_LANES*OPC-1:0] rx_k, // control character flags
    input wire multiframe_strobe_in, // incoming timing strobe
    output reg sync_n, // sync request, active low
    output reg multiframe_strobe_out, // outgoing timing strobe
    output reg [MAX_LANES*OPC*8-1:0] user_data, // lane octets out
    output reg [MAX_LANES*OPC-1:0] user_k, // control flags out
    output reg user_valid, // user data phase
    output reg lmfc_pulse, // multiframe clock boundary
    output reg frame_pulse // frame clock boundary
);
    localparam ST_CGS = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_ILA = 2'd2;
    localparam ST_DATA = 2'd3;
    localparam [14:0] OPC_W = OPC;

    reg [1:0] state;
    reg enable;
    reg [1:0] subclass;
    reg [8:0] cfg_f;
    reg [5:0] cfg_k;
    reg [2:0] cfg_l;
    reg [2:0] cfg_cf;
    reg [1:0] cfg_cs;
    reg resync;
    reg cfg_err;
    reg [3:0] adjust_step_count;
    reg adjust_direction;
    reg phase_adjust_request;

    // Lane inputs come from the transceiver domain and are retimed first.
    reg [MAX_LANES*OPC*8-1:0] data_m;
    reg [MAX_LANES*OPC*8-1:0] data_s;
    reg [MAX_LANES*OPC-1:0] k_m;
    reg [MAX_LANES*OPC-1:0] k_s;
    reg strobe_m;
    reg strobe_s;
    reg strobe_d;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_m <= {MAX_LANES*OPC*8{1'b0}};
            data_s <= {MAX_LANES*OPC*8{1'b0}};
            k_m <= {MAX_LANES*OPC{1'b0}};
            k_s <= {MAX_LANES*OPC{1'b0}};
            strobe_m <= 1'b0;
            strobe_s <= 1'b0;
            strobe_d <= 1'b0;
        end else begin
            data_m <= rx_data;
            data_s <= data_m;
            k_m <= rx_k;
            k_s <= k_m;
            strobe_m <= multiframe_strobe_in;
            strobe_s <= strobe_m;
            strobe_d <= strobe_s;
        end
    end

    wire strobe_rise = strobe_s & ~strobe_d;
    wire syncing = (state == ST_CGS) || (state == ST_WAIT);

    // Multiframe and frame counters count octets, OPC per cycle.
    wire [14:0] mf_len = cfg_f * cfg_k;
    wire [14:0] quarter = (mf_len + 15'd3) >> 2;
    wire [16:0] ila_limit = {mf_len, 2'b00};
    reg [14:0] lmfc_cnt;
    reg [8:0] frame_cnt;
    reg [14:0] lmfc_sum;
    reg [9:0] frame_sum;
    reg lmfc_wrap;
    reg frame_wrap;
    reg [14:0] next_lmfc;
    reg [8:0] next_frame;

    always @* begin
        lmfc_sum = lmfc_cnt + OPC_W;
        frame_sum = {1'b0, frame_cnt} + OPC_W[9:0];
        lmfc_wrap = lmfc_sum >= mf_len;
        frame_wrap = frame_sum >= {1'b0, cfg_f};
        next_lmfc = lmfc_wrap ? lmfc_sum - mf_len : lmfc_sum;
        next_frame = frame_wrap ? frame_sum[8:0] - cfg_f : frame_sum[8:0];
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lmfc_cnt <= 15'h0000;
            frame_cnt <= 9'h000;
            lmfc_pulse <= 1'b0;
            frame_pulse <= 1'b0;
            multiframe_strobe_out <= 1'b0;
        end else begin
            if (syncing && subclass == 2'd1 && strobe_rise) begin
                lmfc_cnt <= 15'h0000;
                frame_cnt <= 9'h000;
                lmfc_pulse <= 1'b1;
                frame_pulse <= 1'b1;
            end else begin
                lmfc_cnt <= next_lmfc;
                frame_cnt <= next_frame;
                lmfc_pulse <= lmfc_wrap;
                frame_pulse <= frame_wrap;
            end
            if (lmfc_wrap) begin
                multiframe_strobe_out <= syncing && subclass == 2'd1;
            end else if (lmfc_cnt >= quarter) begin
                multiframe_strobe_out <= 1'b0;
            end
        end
    end

    // Per-lane comma counting and alignment sequence tracking.
    wire [MAX_LANES-1:0] lane_cgs;
    wire [MAX_LANES-1:0] lane_r;
    wire [MAX_LANES-1:0] lane_a;
    wire [MAX_LANES-1:0] lane_done;
    genvar g;
    generate
        for (g = 0; g < MAX_LANES; g = g + 1) begin : lane
            reg [2:0] commas;
            reg seen_r;
            reg seen_a;
            reg after_a;
            reg done;
            reg [2:0] next_commas;
            reg next_seen_r;
            reg next_seen_a;
            reg next_after_a;
            reg next_done;
            reg [7:0] oc;
            reg kc;
            integer j;
            wire on = (g <= cfg_l);
            always @* begin
                next_commas = commas;
                next_seen_r = seen_r;
                next_seen_a = seen_a;
                next_after_a = after_a;
                next_done = done;
                oc = 8'h00;
                kc = 1'b0;
                for (j = 0; j < OPC; j = j + 1) begin
                    oc = data_s[(g*OPC+j)*8 +: 8];
                    kc = k_s[g*OPC+j];
                    if (syncing) begin
                        if (kc && oc == `K28_5) begin
                            if (next_commas < `COMMA_MIN)
                                next_commas = next_commas + 3'd1;
                        end else begin
                            next_commas = 3'd0;
                        end
                    end else begin
                        // A multiframe end not followed by a new start
                        // ends alignment, extra subclass 0 frames included.
                        if (next_after_a && !(kc && oc == `K28_0))
                            next_done = 1'b1;
                        next_after_a = kc && oc == `K28_3 && next_seen_r;
                        if (kc && oc == `K28_0)
                            next_seen_r = 1'b1;
                        if (next_after_a)
                            next_seen_a = 1'b1;
                    end
                end
                if (state == ST_CGS) begin
                    next_seen_r = 1'b0;
                    next_seen_a = 1'b0;
                    next_after_a = 1'b0;
                    next_done = 1'b0;
                end else if (!syncing) begin
                    next_commas = 3'd0;
                end
            end
            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    commas <= 3'd0;
                    seen_r <= 1'b0;
                    seen_a <= 1'b0;
                    after_a <= 1'b0;
                    done <= 1'b0;
                end else begin
                    commas <= next_commas;
                    seen_r <= next_seen_r;
                    seen_a <= next_seen_a;
                    after_a <= next_after_a;
                    done <= next_done;
                end
            end
            assign lane_cgs[g] = ~on | (commas >= `COMMA_MIN);
            assign lane_r[g] = ~on | seen_r;
            assign lane_a[g] = on & seen_a;
            assign lane_done[g] = ~on | done;
        end
    endgenerate

    // Lane 0 configuration capture; the octet after K28.4 comes first.
    reg [111:0] cfg_shift;
    reg [3:0] cap_cnt;
    reg cap_arm;
    reg checked;
    reg [111:0] next_shift;
    reg [3:0] next_cap;
    reg next_arm;
    reg [7:0] c_oc;
    reg c_k;
    integer i;
    always @* begin
        next_shift = cfg_shift;
        next_cap = cap_cnt;
        next_arm = cap_arm;
        c_oc = 8'h00;
        c_k = 1'b0;
        for (i = 0; i < OPC; i = i + 1) begin
            c_oc = data_s[i*8 +: 8];
            c_k = k_s[i];
            if (next_arm && next_cap < `CFG_OCTETS) begin
                next_shift = {next_shift[103:0], c_oc};
                next_cap = next_cap + 4'd1;
            end else if (c_k && c_oc == `K28_4 && next_cap == 4'd0) begin
                next_arm = 1'b1;
            end
        end
        if (syncing) begin
            next_cap = 4'd0;
            next_arm = 1'b0;
        end
    end

    wire [7:0] oct1 = cfg_shift[103:96];
    wire [7:0] oct2 = cfg_shift[95:88];
    wire [7:0] oct3 = cfg_shift[87:80];
    wire [7:0] oct4 = cfg_shift[79:72];
    wire [7:0] oct5 = cfg_shift[71:64];
    wire [7:0] oct7 = cfg_shift[55:48];
    wire [7:0] oct10 = cfg_shift[31:24];
    wire [7:0] oct11 = cfg_shift[23:16];
    wire [8:0] f_minus = cfg_f - 9'h001;
    wire [5:0] k_minus = cfg_k - 6'h01;
    wire mismatch = (oct3[4:0] != {2'b00, cfg_l}) ||
        (oct4 != f_minus[7:0]) || (oct5[4:0] != k_minus[4:0]) ||
        (oct7[7:5] != {1'b0, subclass}) || (oct10[7:6] != cfg_cs) ||
        (oct11[4:0] != {2'b00, cfg_cf});
    wire check_now = (cap_cnt == `CFG_OCTETS) && !checked;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_shift <= 112'h0;
            cap_cnt <= 4'd0;
            cap_arm <= 1'b0;
            checked <= 1'b0;
            adjust_step_count <= 4'h0;
            adjust_direction <= 1'b0;
            phase_adjust_request <= 1'b0;
        end else begin
            cfg_shift <= next_shift;
            cap_cnt <= next_cap;
            cap_arm <= next_arm;
            checked <= syncing ? 1'b0 : (checked | check_now);
            if (check_now) begin
                // Stored for inspection only; local timing never moves.
                adjust_step_count <= oct1[7:4];
                adjust_direction <= oct2[6];
                phase_adjust_request <= oct2[5];
            end
        end
    end

    // Link state machine and sync request.
    reg [16:0] ila_timer;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_CGS;
            ila_timer <= 17'h00000;
            sync_n <= 1'b0;
            user_valid <= 1'b0;
            user_data <= {MAX_LANES*OPC*8{1'b0}};
            user_k <= {MAX_LANES*OPC{1'b0}};
        end else begin
            user_data <= data_s;
            user_k <= k_s;
            user_valid <= (state == ST_DATA);
            sync_n <= !syncing;
            if (!enable || resync) begin
                state <= ST_CGS;
            end else begin
                case (state)
                    ST_CGS: begin
                        ila_timer <= 17'h00000;
                        if (&lane_cgs)
                            state <= (subclass == 2'd2) ? ST_WAIT : ST_ILA;
                    end
                    ST_WAIT: begin
                        if (lmfc_wrap)
                            state <= ST_ILA;
                    end
                    ST_ILA: begin
                        ila_timer <= ila_timer + 17'h00001;
                        if (&lane_done)
                            state <= ST_DATA;
                        else if (ila_timer >= ila_limit - 17'h00001 &&
                            !(&lane_r))
                            state <= ST_CGS;
                    end
                    ST_DATA: state <= ST_DATA;
                    default: state <= ST_CGS;
                endcase
            end
        end
    end

    // Wishbone slave: one wait state, writes land on the edge that ends the acknowledge cycle.
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire [5:0] widx = wb_adr_i[7:2];
    reg [31:0] rd;
    always @* begin
        rd = 32'h00000000;
        case (widx)
            `ADR_CTRL: begin
                rd[`CTRL_ENABLE] = enable;
                rd[`CTRL_SUB_POS +: 2] = subclass;
            end
            `ADR_CFG0: begin
                rd[8:0] = cfg_f;
                rd[`CFG0_K_POS +: 6] = cfg_k;
                rd[`CFG0_L_POS +: 3] = cfg_l;
            end
            `ADR_CFG1: begin
                rd[2:0] = cfg_cf;
                rd[`CFG1_CS_POS +: 2] = cfg_cs;
            end
            `ADR_STATUS: begin
                rd[0] = sync_n;
                rd[2:1] = state;
                rd[`ST_ERR] = cfg_err;
                rd[`ST_ALIGN_POS +: MAX_LANES] = lane_a;
                rd[`ST_CGS_POS +: MAX_LANES] = lane_cgs;
            end
            `ADR_ADJUST: begin
                rd[3:0] = adjust_step_count;
                rd[4] = adjust_direction;
                rd[5] = phase_adjust_request;
            end
            default: rd = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            enable <= 1'b0;
            subclass <= `RST_SUB;
            cfg_f <= `RST_F;
            cfg_k <= `RST_K;
            cfg_l <= `RST_L;
            cfg_cf <= `RST_CF;
            cfg_cs <= `RST_CS;
            resync <= 1'b0;
            cfg_err <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= rd;
            resync <= 1'b0;
            if (wb_wr && widx == `ADR_CTRL && wb_sel_i[0]) begin
                enable <= wb_dat_i[`CTRL_ENABLE];
                subclass <= wb_dat_i[`CTRL_SUB_POS +: 2];
                resync <= wb_dat_i[`CTRL_RESYNC];
            end
            if (wb_wr && widx == `ADR_CFG0) begin
                if (wb_sel_i[0])
                    cfg_f[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    cfg_f[8] <= wb_dat_i[8];
                if (wb_sel_i[2])
                    cfg_k <= wb_dat_i[`CFG0_K_POS +: 6];
                if (wb_sel_i[3])
                    cfg_l <= wb_dat_i[`CFG0_L_POS +: 3];
            end
            if (wb_wr && widx == `ADR_CFG1 && wb_sel_i[0]) begin
                cfg_cf <= wb_dat_i[2:0];
                cfg_cs <= wb_dat_i[`CFG1_CS_POS +: 2];
            end
            // A mismatch found in the clearing cycle keeps the flag set.
            if (check_now && mismatch)
                cfg_err <= 1'b1;
            else if (wb_wr && widx == `ADR_STATUS && wb_sel_i[0] &&
                wb_dat_i[`ST_ERR])
                cfg_err <= 1'b0;
        end
    end
endmodule // rx_link_sync

// file: rx_link_sync_monitor.sv
`timescale 1ns/1ps
module rx_link_sync_monitor (
    input wire sys_clk, // clock
    input wire arst_n, // async reset, active low
    input wire wb_cyc_i, // bus cycle
    input wire wb_stb_i, // bus strobe
    input wire wb_ack_o, // bus acknowledge
    input wire sync_n, // sync request, active low
    input wire multiframe_strobe_out, // outgoing timing strobe
    input wire user_valid, // data phase
    input wire lmfc_pulse // multiframe boundary
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("request not answered next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    ila_timeout_a: assert property ($rose(sync_n) |-> ##[1:90]
        (!sync_n || user_valid)) else $error("no resync after timeout");
    valid_link_a: assert property (!sync_n [*2] |-> !user_valid)
        else $error("data phase while sync requested");
    strobe_start_a: assert property ($rose(multiframe_strobe_out) |->
        lmfc_pulse && !sync_n) else $error("strobe off boundary");
    // The strobe holds four cycles of the bench's nine-cycle multiframe; three are checked.
    strobe_width_a: assert property ($rose(multiframe_strobe_out) |->
        multiframe_strobe_out [*3]) else $error("strobe too short");
    // Once the link runs, boundaries keep a fixed nine-cycle spacing.
    mf_period_a: assert property (lmfc_pulse && sync_n |=>
        (!lmfc_pulse || !sync_n) [*8] ##1 (lmfc_pulse || !sync_n))
        else $error("multiframe spacing broken");
    cover property ($rose(user_valid));
    cover property ($rose(multiframe_strobe_out));
    cover property ($fell(sync_n));
endmodule // rx_link_sync_monitor

// file: tx_model.sv
`timescale 1ns/1ps
`include "rx_link_consts.vh"
module tx_model #(parameter int LN = 2, parameter int OPC = 2) (
    input wire logic sys_clk, // lane clock
    input wire logic sync_n, // sync request, active low
    input wire logic mute, // withhold the alignment sequence
    input wire logic [111:0] cfg, // config octets, first at bit 0
    input wire logic [8*OPC-1:0] pay, // data phase octets
    output logic [LN*OPC*8-1:0] rx_data = '0, // lane octets
    output logic [LN*OPC-1:0] rx_k = '0 // control flags
);
    // Multiframes of 18 octets; the alignment sequence holds four of them.
    int pos = 0;
    always @(posedge sys_clk) begin
        for (int j = 0; j < OPC; j++) begin
            int m;
            logic [8:0] v;
            m = (pos + j) % 18;
            if (!sync_n || mute) v = {1'b1, `K28_5};
            else if (pos >= 72) v = {1'b0, pay[j*8 +: 8]};
            else if (m == 0) v = {1'b1, `K28_0};
            else if (m == 17) v = {1'b1, `K28_3};
            else if (pos / 18 != 1 || m > 15) v = {1'b0, 8'(m)};
            else if (m == 1) v = {1'b1, `K28_4};
            else v = {1'b0, cfg[(m-2)*8 +: 8]};
            for (int g = 0; g < LN; g++) begin
                rx_data[(g*OPC+j)*8 +: 8] <= v[7:0];
                rx_k[g*OPC+j] <= v[8];
            end
        end
        pos <= (!sync_n || mute) ? 0 : (pos < 72 ? pos + OPC : pos);
    end
endmodule // tx_model

// file: rx_link_sync_bench.sv
`timescale 1ns/1ps
module rx_link_sync_bench;
    logic sys_clk = 0;
    logic arst_n = 0;
    logic wb_cyc = 0;
    logic wb_we = 0;
    logic [7:0] wb_adr = '0;
    logic [31:0] wb_dat = '0;
    logic [31:0] rdat, rx_data, user_data;
    logic ack, sync_n, so, user_valid, lmfc, frame;
    logic strobe_in = 0;
    logic mute = 0;
    logic so_seen = 0;
    logic so_clr = 0;
    logic [3:0] hk [3];
    logic lmfc_prev = 0;
    logic [3:0] rx_k, user_k;
    logic [111:0] cfg = '0;
    logic [15:0] pay = '0;
    logic [31:0] h [3];
    int bad_count = 0;
    int checked = 0;
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    rx_link_sync #(.MAX_LANES(2), .OPC(2)) i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_data(rx_data), .rx_k(rx_k), .multiframe_strobe_in(strobe_in),
        .sync_n(sync_n), .multiframe_strobe_out(so),
        .user_data(user_data), .user_k(user_k), .user_valid(user_valid),
        .lmfc_pulse(lmfc), .frame_pulse(frame));
    tx_model #(.LN(2), .OPC(2)) i_tx (.sys_clk(sys_clk), .sync_n(sync_n),
        .mute(mute), .cfg(cfg), .pay(pay), .rx_data(rx_data), .rx_k(rx_k));
    // Reads right after an edge see the values settled before it.
    always @(posedge sys_clk) begin
        h[0] <= rx_data;
        h[1] <= h[0];
        h[2] <= h[1];
        hk[0] <= rx_k;
        hk[1] <= hk[0];
        hk[2] <= hk[1];
        pay <= 16'($urandom);
        lmfc_prev <= lmfc;
        so_seen <= so_clr ? 1'b0 : (so_seen | so);
    end
    task automatic results();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        q = rdat;
        wb_cyc <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_on(input int w, input logic v, output int n);
        n = 0;
        while ((w == 0 ? sync_n : w == 1 ? user_valid : lmfc) !== v
               && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            $display("[ERR] %0t wait for event expired", $time);
        end
    endtask
    function automatic logic [111:0] mk(logic [5:0] adj, logic [1:0] sub,
                                        logic [31:0] c, logic bad);
        return {16'h0, 5'h0, c[2:0], c[5:4], 6'h0, 16'h0, 1'b0, sub, 5'h0,
                8'h0, 8'h08, 7'h0, ~bad, 8'h01, 1'b0, adj[4], adj[5], 5'h0,
                adj[3:0], 4'h0, 8'h0};
    endfunction
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        $display("[ERR] %0t run timed out", $time);
        results();
    end
    initial begin
        logic [31:0] q;
        logic [31:0] c1;
        logic [5:0] adj;
        int n;
        void'($urandom(78032));
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        wb(0, 8'h04, 0, q);
        chk(q, 32'h00090002);
        wb(0, 8'h3c, 0, q);
        chk(q, 0);
        wb(0, 8'h0c, 0, q);
        chk(q & 32'h1, 0);
        c1 = {26'h0, 2'($urandom_range(3)), 1'b0, 3'($urandom_range(7))};
        wb(1, 8'h08, c1, q);
        wb(0, 8'h08, 0, q);
        chk(q, c1);
        wb(1, 8'h04, 32'h01090002, q);
        wb(0, 8'h04, 0, q);
        chk(q, 32'h01090002);
        $display("test registers done");
        wb(1, 8'h00, 32'h2, q);
        repeat (20) @(posedge sys_clk);
        chk(so_seen, 1);
        wait_on(2, 1, n);
        strobe_in <= 1'b1;
        repeat (2) @(posedge sys_clk);
        strobe_in <= 1'b0;
        wait_on(2, 1, n);
        chk(n < 6, 1);
        $display("test strobes done");
        for (int s = 0; s < 3; s++) begin
            adj = 6'($urandom);
            adj[4] = s[0];
            cfg <= mk(adj, 2'(s), c1, 1'b0);
            wb(1, 8'h00, {28'h0, 1'b1, 2'(s), 1'b1}, q);
            wait_on(0, 0, n);
            wait_on(0, 1, n);
            if (s == 2) chk(lmfc_prev, 1);
            wait_on(1, 1, n);
            chk(n < 300, 1);
            wb(0, 8'h0c, 0, q);
            chk(q & 32'hf, 32'h7);
            wb(0, 8'h10, 0, q);
            chk(q, {26'h0, adj});
            repeat (8) begin
                @(posedge sys_clk);
                chk(user_data, h[2]);
                chk(user_k, hk[2]);
                chk(frame, 1);
            end
            so_clr <= 1'b1;
            strobe_in <= 1'b1;
            repeat (2) @(posedge sys_clk);
            so_clr <= 1'b0;
            strobe_in <= 1'b0;
            repeat (20) @(posedge sys_clk);
            chk(so_seen, 0);
            $display("test subclass %0d done", s);
        end
        cfg <= mk(adj, 2'h2, c1, 1'b1);
        wb(1, 8'h00, 32'hd, q);
        wait_on(0, 0, n);
        wait_on(0, 1, n);
        repeat (60) @(posedge sys_clk);
        wb(0, 8'h0c, 0, q);
        chk(q & 32'h8, 32'h8);
        cfg <= mk(adj, 2'h2, c1, 1'b0);
        wb(1, 8'h0c, 32'h8, q);
        wb(0, 8'h0c, 0, q);
        chk(q & 32'h8, 32'h0);
        $display("test mismatch done");
        // Commas only, so the alignment wait must expire and resync.
        mute <= 1'b1;
        wb(1, 8'h00, 32'h9, q);
        wait_on(0, 0, n);
        wait_on(0, 1, n);
        wait_on(0, 0, n);
        chk(n >= 71 && n <= 80, 1);
        mute <= 1'b0;
        wait_on(1, 1, n);
        chk(n < 300, 1);
        $display("test timeout done");
        results();
    end
endmodule // rx_link_sync_bench
bind rx_link_sync rx_link_sync_monitor i_mon (.sys_clk(sys_clk),
    .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sync_n(sync_n),
    .multiframe_strobe_out(multiframe_strobe_out),
    .user_valid(user_valid), .lmfc_pulse(lmfc_pulse));
